//--- tmoec_top.sv
// Top of the timer one-shot and edge control block with AHB-Lite registers
//
// The register offsets and the AHB-Lite register port were chosen for this implementation.
module tmoec_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic edge_input_pin,
  output logic valid_edge_q,
  output logic one_shot_pulse_q,
  output logic timer_out_q,
  output logic count_tick_q
);
  logic run_q;
  logic [tmoec_pkg::OUTC_WIDTH-1:0] outc_q;
  logic [tmoec_pkg::PRES_WIDTH-1:0] prescaler_select_register;
  logic [5:0] mode_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;
  logic pin_meta_q;
  logic pin_sync_q;
  logic [tmoec_pkg::DIV_WIDTH-1:0] div_q;
  logic tick;
  logic [1:0] gap_q;
  logic trig_wr;
  logic edge_det;
  tmoec_pkg::tmoec_out_s out_s;
  tmoec_pkg::tmoec_edge_e edge_sel;

  // Address match on a word aligned offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  // Responses are always zero wait state OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Capture address phase; only NONSEQ and SEQ start a transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= hsel && htrans[1] && hwrite;
      rd_pend_q <= hsel && htrans[1] && !hwrite;
      addr_q <= haddr;
    end
  end

  // Read data registered for the data phase; unmapped offsets read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= 32'h00000000;
      if (hit(haddr, tmoec_pkg::ADDR_CTRL)) begin
        hrdata[tmoec_pkg::CTRL_RUN] <= run_q;
      end else if (hit(haddr, tmoec_pkg::ADDR_OUTC)) begin
        // Trigger, set and reset are strobes and always read back zero
        hrdata[tmoec_pkg::OUTC_OE] <= outc_q[tmoec_pkg::OUTC_OE];
      end else if (hit(haddr, tmoec_pkg::ADDR_PRES)) begin
        hrdata[tmoec_pkg::PRES_WIDTH-1:0] <= prescaler_select_register;
      end else if (hit(haddr, tmoec_pkg::ADDR_MODE)) begin
        hrdata[5:0] <= mode_q;
      end else if (hit(haddr, tmoec_pkg::ADDR_STAT)) begin
        hrdata[0] <= pin_sync_q;
        hrdata[1] <= out_s.level;
        hrdata[3:2] <= gap_q;
      end
    end
  end

  // Run control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q <= 1'b0;
    end else if (wr_pend_q && hit(addr_q, tmoec_pkg::ADDR_CTRL)) begin
      run_q <= hwdata[tmoec_pkg::CTRL_RUN];
    end
  end

  // Prescaler and mode taken as written; software stops the timer first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescaler_select_register <= tmoec_pkg::PRES_RST;
      mode_q <= tmoec_pkg::MODE_RST;
    end else if (wr_pend_q) begin
      if (hit(addr_q, tmoec_pkg::ADDR_PRES)) begin
        prescaler_select_register <= hwdata[tmoec_pkg::PRES_WIDTH-1:0];
      end
      if (hit(addr_q, tmoec_pkg::ADDR_MODE)) begin
        mode_q <= hwdata[5:0];
      end
    end
  end

  // Output control: whole byte store; strobes clear themselves next cycle
  assign trig_wr = wr_pend_q && hit(addr_q, tmoec_pkg::ADDR_OUTC)
    && hwdata[tmoec_pkg::OUTC_TRIG];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      outc_q <= tmoec_pkg::OUTC_RST;
    end else if (wr_pend_q && hit(addr_q, tmoec_pkg::ADDR_OUTC)) begin
      outc_q <= hwdata[tmoec_pkg::OUTC_WIDTH-1:0];
    end else begin
      outc_q[tmoec_pkg::OUTC_TRIG] <= 1'b0;
      outc_q[tmoec_pkg::OUTC_LVS] <= 1'b0;
      outc_q[tmoec_pkg::OUTC_LVR] <= 1'b0;
    end
  end

  // Output level: set and reset act even while disabled, set first; a lone set write also clears the enable, so the output is high for one cycle only
  assign out_s.oe = outc_q[tmoec_pkg::OUTC_OE];
  assign out_s.level = timer_out_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_out_q <= 1'b0;
    end else if (outc_q[tmoec_pkg::OUTC_LVS]) begin
      timer_out_q <= 1'b1;
    end else if (outc_q[tmoec_pkg::OUTC_LVR]) begin
      timer_out_q <= 1'b0;
    end else if (!out_s.oe) begin
      timer_out_q <= 1'b0;
    end
  end

  // Count clock enable: divide by 4 to the power of the select code
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= '0;
    end else if (tick || !run_q) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end
  assign tick = run_q && (div_q == 8'((1 << (tmoec_pkg::PRES_SHIFT_STEP
    * prescaler_select_register)) - 1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_tick_q <= 1'b0;
    end else begin
      count_tick_q <= mode_q[tmoec_pkg::MODE_CNT_PIN] ? edge_det : tick;
    end
  end

  // Trigger spacing: a trigger on or before the second count clock after the last accepted one is dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_q <= tmoec_pkg::TRIG_GAP_CYC;
    end else if (trig_wr && gap_q == tmoec_pkg::TRIG_GAP_CYC) begin
      gap_q <= 2'h0;
    end else if (tick && gap_q != tmoec_pkg::TRIG_GAP_CYC) begin
      gap_q <= gap_q + 2'h1;
    end
  end

  // One-shot pulse only honoured in one-shot mode with the timer running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      one_shot_pulse_q <= 1'b0;
    end else begin
      one_shot_pulse_q <= trig_wr && run_q && mode_q[tmoec_pkg::MODE_ONESHOT]
        && gap_q == tmoec_pkg::TRIG_GAP_CYC;
    end
  end

  // Two stage synchroniser for the edge pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= edge_input_pin;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign edge_sel = tmoec_pkg::tmoec_edge_e'(mode_q[tmoec_pkg::MODE_EDGE_LO +: 2]);
  tmoec_edge u_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_sync(pin_sync_q),
    .run(run_q),
    .sel(edge_sel),
    .edge_q(edge_det)
  );

  // Edge reported outward, registered one cycle after the detector output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      valid_edge_q <= 1'b0;
    end else begin
      valid_edge_q <= edge_det;
    end
  end
endmodule

//--- tmoec_pkg.sv
// Package for the timer one-shot and edge control block: map, fields, types
package tmoec_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OUTC = 8'h04;
  localparam logic [7:0] ADDR_PRES = 8'h08;
  localparam logic [7:0] ADDR_MODE = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  // Control register fields
  localparam int CTRL_RUN = 0;
  // Output control fields
  localparam int OUTC_TRIG = 0;
  localparam int OUTC_OE = 1;
  localparam int OUTC_LVS = 2;
  localparam int OUTC_LVR = 3;
  localparam int OUTC_WIDTH = 8;
  // Mode register fields
  localparam int MODE_EDGE_LO = 0;
  localparam int MODE_ONESHOT = 2;
  localparam int MODE_CNT_PIN = 3;
  localparam int MODE_CLR_PIN = 4;
  localparam int MODE_CAP_PIN = 5;
  // Prescaler select width and reset values of prescaler, mode and output control
  localparam int PRES_WIDTH = 2;
  localparam logic [1:0] PRES_RST = 2'h0;
  localparam logic [5:0] MODE_RST = 6'h00;
  localparam logic [7:0] OUTC_RST = 8'h00;
  // Prescaler division exponent per select code and divider counter width
  localparam int PRES_SHIFT_STEP = 2;
  localparam int DIV_WIDTH = 8;
  // Count clocks that must pass after an accepted trigger before the next one is taken
  localparam logic [1:0] TRIG_GAP_CYC = 2'h2;
  // Valid edge selection
  typedef enum logic [1:0] {
    TMOEC_EDGE_FALL = 2'b00,
    TMOEC_EDGE_RISE = 2'b01,
    TMOEC_EDGE_NONE = 2'b10,
    TMOEC_EDGE_BOTH = 2'b11
  } tmoec_edge_e;
  // Output control state used inside tmoec_top only
  typedef struct packed {
    logic oe;
    logic level;
  } tmoec_out_s;
endpackage

//--- tmoec_edge.sv
// Valid edge detector that holds its last level while counting is stopped
module tmoec_edge (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin_sync,
  input wire logic run,
  input wire tmoec_pkg::tmoec_edge_e sel,
  output logic edge_q
);
  logic held_q;
  // Held level resets low so a high pin gives a rising edge at first enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_q <= 1'b0;
    end else if (run) begin
      held_q <= pin_sync;
    end
  end
  // First sample after enable is compared with the level held while stopped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_q <= 1'b0;
    end else begin
      unique case (sel)
        tmoec_pkg::TMOEC_EDGE_RISE: edge_q <= run && pin_sync && !held_q;
        tmoec_pkg::TMOEC_EDGE_FALL: edge_q <= run && !pin_sync && held_q;
        tmoec_pkg::TMOEC_EDGE_BOTH: edge_q <= run && (pin_sync != held_q);
        tmoec_pkg::TMOEC_EDGE_NONE: edge_q <= 1'b0;
      endcase
    end
  end
endmodule

//--- tmoec_src.sv
// External edge source model driving the timer edge input pin
module tmoec_src (
  input wire logic hclk,
  input wire logic lvl,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Level moves only just after an edge; the bench holds each level for many count clocks
  always @(posedge hclk) pin <= lvl;
endmodule

//--- tmoec_top_chk.sv
// Port checker for the timer one-shot and edge control block
module tmoec_top_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic edge_input_pin,
  input wire logic valid_edge_q,
  input wire logic one_shot_pulse_q,
  input wire logic timer_out_q
);
  logic [7:0] a_q;
  logic v_q, w_q, run_q, rise_q, wr_o, rd_o;
  logic [2:0] stop_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Address phase kept so the data phase can be decoded
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      v_q <= 1'b0;
      w_q <= 1'b0;
      a_q <= 8'h00;
    end else begin
      v_q <= hsel & htrans[1] & hreadyout;
      w_q <= hwrite;
      a_q <= haddr;
    end
  end
  // Run bit and rising edge select as last written
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q <= 1'b0;
      rise_q <= 1'b0;
    end else if (v_q & w_q & (a_q == tmoec_pkg::ADDR_CTRL)) begin
      run_q <= hwdata[0];
    end else if (v_q & w_q & (a_q == tmoec_pkg::ADDR_MODE)) begin
      rise_q <= hwdata[0];
    end
  end
  // Saturating count of stopped cycles; the margin covers the pin pipeline
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) stop_q <= 3'h0;
    else if (run_q) stop_q <= 3'h0;
    else if (stop_q != 3'h7) stop_q <= stop_q + 3'h1;
  end
  assign wr_o = v_q & w_q & (a_q == tmoec_pkg::ADDR_OUTC);
  assign rd_o = v_q & !w_q & (a_q == tmoec_pkg::ADDR_OUTC);
  sequence s_rise_run;
    run_q && rise_q && $rose(edge_input_pin);
  endsequence
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  chk_trig_reads_zero: assert property (rd_o |-> !hrdata[0])
    else $error("trigger bit read as one");
  chk_level_reads_zero: assert property (rd_o |-> hrdata[3:2] == 2'h0)
    else $error("level bits read as nonzero");
  chk_set_out_high: assert property (wr_o && hwdata[1] && hwdata[2] |-> ##[1:2] timer_out_q)
    else $error("level set did not raise output");
  chk_reset_out_low: assert property (wr_o && hwdata[1] && hwdata[3] && !hwdata[2]
    |-> ##[1:2] !timer_out_q)
    else $error("level reset did not lower output");
  chk_osp_single: assert property (one_shot_pulse_q |=> !one_shot_pulse_q)
    else $error("one-shot pulses too close");
  chk_rise_seen: assert property (s_rise_run |-> ##[2:5] valid_edge_q)
    else $error("rising edge not detected");
  chk_quiet_stopped: assert property (stop_q == 3'h7 |-> !valid_edge_q)
    else $error("edge reported while stopped");
endmodule
bind tmoec_top tmoec_top_chk chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hrdata, .hreadyout, .hresp, .edge_input_pin, .valid_edge_q,
  .one_shot_pulse_q, .timer_out_q);

//--- test_timer_oneshot_edge_control.sv
// Testbench for the timer one-shot and edge control block
module test_timer_oneshot_edge_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, lvl = 1'b1;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic hready, hreadyout, hresp, edge_input_pin, valid_edge_q;
  logic one_shot_pulse_q, timer_out_q, count_tick_q;
  int errors = 0, n_tests = 0, n_edge = 0, n_osp = 0, n_tick = 0, e0, t0;
  `define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
  always #2 hclk = ~hclk;
  assign hready = hreadyout;
  // Pulses counted on the falling edge, where outputs are settled
  always @(negedge hclk) begin
    if (valid_edge_q === 1'b1) n_edge++;
    if (one_shot_pulse_q === 1'b1) n_osp++;
    if (count_tick_q === 1'b1) n_tick++;
  end
  tmoec_src src (.hclk(hclk), .lvl(lvl), .pin(edge_input_pin));
  tmoec_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .edge_input_pin, .valid_edge_q,
    .one_shot_pulse_q, .timer_out_q, .count_tick_q);
  task summarize;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Bounded wait for hready; a hang ends the run
  task rdy;
    int i;
    for (i = 0; i < 16; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (i == 16) begin
      errors++;
      summarize;
    end
  endtask
  // One single AHB-Lite transfer; read data kept in rd
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    rd = hrdata;
  endtask
  // Stop, move the pin, pick the edge, restart and count detections
  task ed(input logic [1:0] m, input logic l, input int exp);
    xfer(tmoec_pkg::ADDR_CTRL, 1'b1, 32'h0);
    lvl <= l;
    repeat (6) @(posedge hclk);
    xfer(tmoec_pkg::ADDR_MODE, 1'b1, {30'h0, m});
    e0 = n_edge;
    xfer(tmoec_pkg::ADDR_CTRL, 1'b1, 32'h1);
    repeat (8) @(posedge hclk);
    `CHK("edge count", exp, n_edge - e0)
  endtask
  // Edges and pin-count ticks while running with both edges selected
  task t_run;
    xfer(tmoec_pkg::ADDR_MODE, 1'b1, 32'h0B);
    // One idle edge so a prescaler tick of the old mode is not counted
    @(posedge hclk);
    e0 = n_edge;
    t0 = n_tick;
    lvl <= 1'b1;
    repeat (8) @(posedge hclk);
    lvl <= 1'b0;
    repeat (8) @(posedge hclk);
    `CHK("running edges", 2, n_edge - e0)
    `CHK("pin count ticks", 2, n_tick - t0)
  endtask
  // Prescaler select one gives a tick every fourth clock
  task t_tick;
    xfer(tmoec_pkg::ADDR_CTRL, 1'b1, 32'h0);
    xfer(tmoec_pkg::ADDR_PRES, 1'b1, 32'h1);
    xfer(tmoec_pkg::ADDR_MODE, 1'b1, 32'h02);
    t0 = n_tick;
    xfer(tmoec_pkg::ADDR_CTRL, 1'b1, 32'h1);
    repeat (40) @(posedge hclk);
    `CHK("prescaled ticks", 9, n_tick - t0)
  endtask
  // Output control writes and read-back while stopped
  task t_out;
    xfer(tmoec_pkg::ADDR_CTRL, 1'b1, 32'h0);
    xfer(tmoec_pkg::ADDR_OUTC, 1'b1, 32'h06);
    repeat (3) @(posedge hclk);
    `CHK("out after set", 1'b1, timer_out_q)
    xfer(tmoec_pkg::ADDR_OUTC, 1'b0, 32'h0);
    `CHK("outc read", 32'h2, rd)
    xfer(tmoec_pkg::ADDR_OUTC, 1'b1, 32'h0A);
    repeat (3) @(posedge hclk);
    `CHK("out after reset", 1'b0, timer_out_q)
    xfer(tmoec_pkg::ADDR_OUTC, 1'b1, 32'h06);
    repeat (3) @(posedge hclk);
    `CHK("out after set", 1'b1, timer_out_q)
    xfer(8'h20, 1'b0, 32'h0);
    `CHK("unmapped read", 32'h0, rd)
  endtask
  // Two spaced one-shot triggers, then one too close that gives no pulse
  task t_trig;
    xfer(tmoec_pkg::ADDR_PRES, 1'b1, 32'h0);
    xfer(tmoec_pkg::ADDR_MODE, 1'b1, 32'h06);
    xfer(tmoec_pkg::ADDR_CTRL, 1'b1, 32'h1);
    e0 = n_osp;
    xfer(tmoec_pkg::ADDR_OUTC, 1'b1, 32'h03);
    repeat (2) @(posedge hclk);
    xfer(tmoec_pkg::ADDR_OUTC, 1'b1, 32'h03);
    xfer(tmoec_pkg::ADDR_OUTC, 1'b1, 32'h03);
    repeat (4) @(posedge hclk);
    `CHK("one-shot pulses", 2, n_osp - e0)
    xfer(tmoec_pkg::ADDR_OUTC, 1'b0, 32'h0);
    `CHK("trigger read", 32'h2, rd)
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ed(2'h1, 1'b1, 1);
    ed(2'h0, 1'b0, 1);
    ed(2'h1, 1'b1, 1);
    ed(2'h3, 1'b1, 0);
    ed(2'h2, 1'b0, 0);
    t_run;
    t_tick;
    t_out;
    t_trig;
    summarize;
  end
endmodule
